// file: logic/orsq_top.sv
// Overview of operation
// - wait turn-on delay after enable, default zero
// - refuse settings outside 0 to 125 ms
// - settings are linear-11 words, Y times 2^N
// - ramp up over rise time, default 5 ms
// - wait turn-off delay after disable, default zero
// - ramp down over fall time, default 5 ms
// - fall under 0.5 ms: both FETs off at once
`timescale 1ns/1ps
module orsq_top
  import orsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // enable pin
  input  wire logic        ENABLE,
  // command port
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        WR_STB,
  input  wire logic [15:0] WR_DATA,
  input  wire logic        RD_STB,
  output logic      [15:0] RD_DATA,
  output logic             RD_VALID,
  output logic             WR_ACK,
  output logic             WR_NACK,
  // power stage control
  output logic             REGULATE,
  output logic             RAMP_UP,
  output logic             RAMP_DOWN,
  output logic             OUTPUT_OFF
);

  ////////////////////////////////////////////////////////////////////////////
  // settings storage

  logic [15:0]       word_q [NUM_SETTINGS];
  logic [TICK_W-1:0] ticks_q [NUM_SETTINGS];
  logic [15:0]       next_word [NUM_SETTINGS];
  logic [TICK_W-1:0] next_ticks [NUM_SETTINGS];
  logic              fall_fast;
  logic              next_fall_fast;
  logic [15:0]       next_rd_data;
  logic              next_rd_valid;
  logic              next_wr_ack;
  logic              next_wr_nack;
  logic              cmd_hit;
  logic [1:0]        cmd_idx;
  logic              dec_ok;
  logic [TICK_W-1:0] dec_ticks;
  logic              dec_fast;

  always_comb begin
    cmd_hit = 1'b1;
    cmd_idx = 2'(IDX_ON_WAIT);
    unique case (CMD_CODE)
      CMD_TURN_ON_WAIT_TIME:  cmd_idx = 2'(IDX_ON_WAIT);
      CMD_RAMP_UP_DURATION:   cmd_idx = 2'(IDX_RISE);
      CMD_TURN_OFF_WAIT_TIME: cmd_idx = 2'(IDX_OFF_WAIT);
      CMD_RAMP_DOWN_DURATION: cmd_idx = 2'(IDX_FALL);
      default:                cmd_hit = 1'b0;
    endcase
  end

  orsq_lin11_decode u_decode (
    .word       (WR_DATA),
    .in_range   (dec_ok),
    .ticks      (dec_ticks),
    .below_fast (dec_fast)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SETTINGS; gi++) begin : g_set
      always_comb begin
        next_word[gi]  = word_q[gi];
        next_ticks[gi] = ticks_q[gi];
        // out-of-range words leave the old setting in force
        if (WR_STB && cmd_hit && cmd_idx == 2'(gi) && dec_ok) begin
          next_word[gi]  = WR_DATA;
          next_ticks[gi] = dec_ticks;
        end
      end
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          word_q[gi]  <= (gi == IDX_RISE || gi == IDX_FALL) ? RST_WORD_RAMP
                                                            : RST_WORD_WAIT;
          ticks_q[gi] <= (gi == IDX_RISE || gi == IDX_FALL) ? RST_TICKS_RAMP
                                                            : RST_TICKS_WAIT;
        end else begin
          word_q[gi]  <= next_word[gi];
          ticks_q[gi] <= next_ticks[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    next_fall_fast = fall_fast;
    if (WR_STB && cmd_hit && cmd_idx == 2'(IDX_FALL) && dec_ok) begin
      next_fall_fast = dec_fast;
    end
    next_wr_ack   = WR_STB && cmd_hit && dec_ok;
    next_wr_nack  = WR_STB && !(cmd_hit && dec_ok);
    next_rd_valid = RD_STB;
    next_rd_data  = RD_DATA;
    if (RD_STB) begin
      next_rd_data = cmd_hit ? word_q[cmd_idx] : 16'h0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fall_fast <= 1'b0;
      RD_DATA   <= 16'h0000;
      RD_VALID  <= 1'b0;
      WR_ACK    <= 1'b0;
      WR_NACK   <= 1'b0;
    end else begin
      fall_fast <= next_fall_fast;
      RD_DATA   <= next_rd_data;
      RD_VALID  <= next_rd_valid;
      WR_ACK    <= next_wr_ack;
      WR_NACK   <= next_wr_nack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  orsq_state_e       state;
  orsq_state_e       next_state;
  logic [DIV_W-1:0]  div_cnt;
  logic [DIV_W-1:0]  next_div_cnt;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              tick;
  logic              en_meta;
  logic              en_s;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      en_meta <= 1'b0;
      en_s    <= 1'b0;
    end else begin
      en_meta <= ENABLE;
      en_s    <= en_meta;
    end
  end

  always_comb begin
    tick          = (div_cnt == DIV_W'(TICK_CYCLES - 1));
    next_state    = state;
    next_div_cnt  = tick ? '0 : div_cnt + 1'b1;
    next_tick_cnt = tick ? tick_cnt + 1'b1 : tick_cnt;
    unique case (state)
      ST_OFF: begin
        if (en_s) next_state = ST_ON_WAIT;
      end
      ST_ON_WAIT: begin
        if (!en_s) next_state = ST_OFF;
        else if (tick_cnt >= ticks_q[IDX_ON_WAIT]) next_state = ST_RISING;
      end
      ST_RISING: begin
        // a disable mid-ramp goes straight to the turn-off wait
        if (!en_s) next_state = ST_OFF_WAIT;
        else if (tick_cnt >= ticks_q[IDX_RISE]) next_state = ST_ON;
      end
      ST_ON: begin
        if (!en_s) next_state = ST_OFF_WAIT;
      end
      ST_OFF_WAIT: begin
        if (en_s) next_state = ST_ON;
        else if (tick_cnt >= ticks_q[IDX_OFF_WAIT]) begin
          next_state = fall_fast ? ST_OFF : ST_FALLING;
        end
      end
      ST_FALLING: begin
        // fall always completes; a new enable is seen once off
        if (tick_cnt >= ticks_q[IDX_FALL]) next_state = ST_OFF;
      end
    endcase
    // every interval is measured from its own entry
    if (next_state != state || state == ST_OFF || state == ST_ON) begin
      next_div_cnt  = '0;
      next_tick_cnt = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state      <= ST_OFF;
      div_cnt    <= '0;
      tick_cnt   <= '0;
      REGULATE   <= 1'b0;
      RAMP_UP    <= 1'b0;
      RAMP_DOWN  <= 1'b0;
      OUTPUT_OFF <= 1'b1;
    end else begin
      state      <= next_state;
      div_cnt    <= next_div_cnt;
      tick_cnt   <= next_tick_cnt;
      REGULATE   <= next_state inside {ST_RISING, ST_ON, ST_OFF_WAIT, ST_FALLING};
      RAMP_UP    <= next_state == ST_RISING;
      RAMP_DOWN  <= next_state == ST_FALLING;
      OUTPUT_OFF <= next_state inside {ST_OFF, ST_ON_WAIT};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_on_wait_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_ON_WAIT && en_s && tick_cnt < ticks_q[IDX_ON_WAIT]) |=> !RAMP_UP;
  endproperty
  a_on_wait_hold: assert property (p_on_wait_hold) else $error("rise began early");

  property p_on_wait_end;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_ON_WAIT && en_s && tick_cnt >= ticks_q[IDX_ON_WAIT])
      |=> RAMP_UP && !OUTPUT_OFF;
  endproperty
  a_on_wait_end: assert property (p_on_wait_end) else $error("rise did not start");

  property p_reject_keeps;
    @(posedge CLK) disable iff (SYS_RST)
    (WR_STB && !dec_ok) |=> $stable(word_q[IDX_RISE]) && $stable(word_q[IDX_FALL]) && WR_NACK;
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("bad value taken");

  property p_decode_default;
    @(posedge CLK) disable iff (SYS_RST)
    (WR_DATA == RST_WORD_RAMP) |-> dec_ok && dec_ticks == RST_TICKS_RAMP && !dec_fast;
  endproperty
  a_decode_default: assert property (p_decode_default) else $error("decode wrong");

  property p_rise_span;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_RISING && en_s && tick_cnt < ticks_q[IDX_RISE]) |=> state == ST_RISING;
  endproperty
  a_rise_span: assert property (p_rise_span) else $error("rise cut short");

  property p_off_wait;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_OFF_WAIT && !en_s && tick_cnt < ticks_q[IDX_OFF_WAIT])
      |=> REGULATE && !RAMP_DOWN;
  endproperty
  a_off_wait: assert property (p_off_wait) else $error("fall began early");

  property p_fall_end;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_FALLING && tick_cnt >= ticks_q[IDX_FALL]) |=> OUTPUT_OFF && !REGULATE;
  endproperty
  a_fall_end: assert property (p_fall_end) else $error("fall did not end");

  property p_fast_off;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_OFF_WAIT && !en_s && fall_fast && tick_cnt >= ticks_q[IDX_OFF_WAIT])
      |=> !REGULATE && !RAMP_DOWN;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("no immediate switch-off");

  property p_tick_spacing;
    @(posedge CLK) disable iff (SYS_RST)
    tick |=> !tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

  property p_state_order;
    @(posedge CLK) disable iff (SYS_RST)
    (state == ST_OFF) |=> state inside {ST_OFF, ST_ON_WAIT};
  endproperty
  a_state_order: assert property (p_state_order) else $error("bad start order");

  c_full_on: cover property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_RISING ##1 state == ST_ON);
  c_full_off: cover property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_FALLING ##1 state == ST_OFF);
  c_fast_off: cover property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_OFF_WAIT ##1 state == ST_OFF);
  c_reject: cover property (@(posedge CLK) disable iff (SYS_RST) WR_NACK);

endmodule

// file: logic/orsq_pkg.sv
package orsq_pkg;

  // command codes of the four timing settings
  localparam logic [7:0] CMD_TURN_ON_WAIT_TIME  = 8'h60;
  localparam logic [7:0] CMD_RAMP_UP_DURATION   = 8'h61;
  localparam logic [7:0] CMD_TURN_OFF_WAIT_TIME = 8'h64;
  localparam logic [7:0] CMD_RAMP_DOWN_DURATION = 8'h65;

  // storage index of each setting
  localparam int unsigned IDX_ON_WAIT  = 0;
  localparam int unsigned IDX_RISE     = 1;
  localparam int unsigned IDX_OFF_WAIT = 2;
  localparam int unsigned IDX_FALL     = 3;
  localparam int unsigned NUM_SETTINGS = 4;

  // linear-11 field layout
  localparam int unsigned L11_EXP_MSB  = 15;
  localparam int unsigned L11_EXP_LSB  = 11;
  localparam int unsigned L11_MANT_MSB = 10;

  // values after reset
  localparam logic [15:0] RST_WORD_WAIT = 16'h0000;
  localparam logic [15:0] RST_WORD_RAMP = 16'hca80;

  // timing base: the interval counter runs in sixteenths of a millisecond
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned TICK_PERIOD_NS  = 62500;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_MS    = 16;
  localparam int          TICK_SHIFT      = 4;
  localparam int unsigned TICK_W          = 11;
  localparam int unsigned DIV_W           = 16;

  // accepted range and thresholds
  localparam int unsigned MAX_TIME_MS   = 125;
  localparam int unsigned MAX_TICKS     = MAX_TIME_MS * TICKS_PER_MS;
  localparam int unsigned FAST_OFF_US   = 500;
  localparam int unsigned FAST_TICKS    = FAST_OFF_US * TICKS_PER_MS / 1000;
  localparam int unsigned RAMP_RST_MS   = 5;
  localparam logic [10:0] RST_TICKS_WAIT = 11'h000;
  localparam logic [10:0] RST_TICKS_RAMP = 11'(RAMP_RST_MS * TICKS_PER_MS);

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_WAIT, ST_RISING, ST_ON, ST_OFF_WAIT, ST_FALLING
  } orsq_state_e;

endpackage

// file: logic/orsq_lin11_decode.sv
`timescale 1ns/1ps
module orsq_lin11_decode
  import orsq_pkg::*;
(
  // setting word
  input  wire logic [15:0] word,
  // decoded result
  output logic             in_range,
  output logic [10:0]      ticks,
  output logic             below_fast
);

  logic signed [4:0]  expo;
  logic signed [10:0] mant;
  logic signed [5:0]  shift;
  logic [31:0]        wide;

  always_comb begin
    expo  = word[L11_EXP_MSB:L11_EXP_LSB];
    mant  = word[L11_MANT_MSB:0];
    shift = 6'(expo) + 6'(TICK_SHIFT);
    if (shift >= 0) begin
      wide = {21'h000000, mant} << shift[4:0];
    end else begin
      // right shift truncates, so a sub-tick remainder is dropped
      wide = {21'h000000, mant} >> 5'(-shift);
    end
    // a negative time is never legal; zero mantissa is zero time
    in_range   = !mant[10] && (wide <= 32'(MAX_TICKS));
    ticks      = wide[10:0];
    below_fast = wide < 32'(FAST_TICKS);
  end

endmodule

// file: dv/orsq_host_model.sv
`timescale 1ns/1ps
module orsq_host_model
  import orsq_pkg::*;
(
  // clock
  input  wire logic        clk,
  // command port towards the device
  output logic      [7:0]  cmd_code,
  output logic             wr_stb,
  output logic      [15:0] wr_data,
  output logic             rd_stb,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        wr_ack,
  input  wire logic        wr_nack
);
  initial begin
    cmd_code = 8'h00;
    wr_stb   = 1'b0;
    wr_data  = 16'h0000;
    rd_stb   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // whole linear-11 word per strobe; callers keep rise at 0.5 ms or more
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    output logic ack, output logic nack);
    @(negedge clk);
    cmd_code = c;
    wr_data  = d;
    wr_stb   = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    ack    = wr_ack;
    nack   = wr_nack;
  endtask

  // missing valid turns the data unknown so no compare can pass
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    rd_stb   = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    d      = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import orsq_pkg::*;
;
  localparam int TC = 4;
  logic        clk, sys_rst, enable, wr_stb, rd_stb, rd_valid, wr_ack, wr_nack;
  logic        regulate, ramp_up, ramp_down, output_off, ack, nack;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data, rd_data, rdv;
  int          fails, comparisons, cycles, n;
  logic [7:0]  codes [4] = '{CMD_TURN_ON_WAIT_TIME, CMD_RAMP_UP_DURATION,
                             CMD_TURN_OFF_WAIT_TIME, CMD_RAMP_DOWN_DURATION};
  logic [15:0] rsts [4]  = '{RST_WORD_WAIT, RST_WORD_RAMP, RST_WORD_WAIT, RST_WORD_RAMP};
  logic [15:0] bad [3]   = '{16'h007e, 16'hf8fb, 16'h07ff};

  orsq_top #(.TICK_CYCLES(TC)) u_orsq_top (
    .CLK(clk), .SYS_RST(sys_rst), .ENABLE(enable), .CMD_CODE(cmd_code),
    .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .WR_ACK(wr_ack), .WR_NACK(wr_nack), .REGULATE(regulate),
    .RAMP_UP(ramp_up), .RAMP_DOWN(ramp_down), .OUTPUT_OFF(output_off));

  orsq_host_model u_orsq_host_model (
    .clk(clk), .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ack(wr_ack),
    .wr_nack(wr_nack));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      $display("Error run length expected below %0d seen %0d", 20000, cycles);
      summarize();
    end
  end

  task chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // timers restart at state entry, so counts are exact; a slip of one edge is a bug
  task rng(string what, int exp, int got);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic logic sel(int k);
    if (k == 0) return ramp_up;
    if (k == 1) return ramp_down;
    return ramp_down | ~regulate;
  endfunction

  task wait_for(int k, logic v);
    n = 0;
    while (sel(k) !== v && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task wreg(logic [7:0] c, logic [15:0] d, logic ok);
    u_orsq_host_model.wr(c, d, ack, nack);
    chk("write response", {14'h0, ok, ~ok}, {14'h0, ack, nack});
  endtask

  task rreg(logic [7:0] c, logic [15:0] exp);
    u_orsq_host_model.rd(c, rdv);
    chk("read data", exp, rdv);
  endtask

  ////////////////////////////////////////////////////////////////
  task power_cycle(string name, int d_on, int r, int d_off, int f);
    @(negedge clk);
    enable = 1'b1;
    wait_for(0, 1'b1);
    rng("turn-on wait cycles", d_on * TC + 4, n);
    chk("rising outputs", 16'h6, {13'h0, regulate, ramp_up, output_off});
    wait_for(0, 1'b0);
    rng("rise cycles", r * TC + 1, n);
    chk("on outputs", 16'h4, {13'h0, regulate, ramp_up, output_off});
    @(negedge clk);
    enable = 1'b0;
    wait_for(2, 1'b1);
    rng("turn-off wait cycles", d_off * TC + 4, n);
    if (f < 8) begin
      chk("fast off outputs", 16'h1, {13'h0, regulate, ramp_down, output_off});
    end else begin
      wait_for(1, 1'b0);
      rng("fall cycles", f * TC + 1, n);
      chk("off outputs", 16'h1, {13'h0, regulate, ramp_down, output_off});
    end
    $display("test %s done", name);
  endtask

  initial begin
    sys_rst     = 1'b1;
    enable      = 1'b0;
    fails       = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) rreg(codes[i], rsts[i]);
    rreg(8'h62, 16'h0000);
    wreg(8'h62, 16'he001, 1'b0);
    $display("test reset values done");
    power_cycle("defaults", 0, 80, 0, 80);
    // 126 ms, 125.5 ms and a negative mantissa are refused; 125 ms is the edge
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) wreg(codes[i], bad[j], 1'b0);
      rreg(codes[i], rsts[i]);
      wreg(codes[i], 16'h007d, 1'b1);
      rreg(codes[i], 16'h007d);
    end
    // the reset encoding written back must decode to the same time
    wreg(CMD_RAMP_UP_DURATION, RST_WORD_RAMP, 1'b1);
    rreg(CMD_RAMP_UP_DURATION, RST_WORD_RAMP);
    $display("test range done");
    wreg(CMD_TURN_ON_WAIT_TIME, 16'he005, 1'b1);
    wreg(CMD_RAMP_UP_DURATION, 16'he804, 1'b1);
    wreg(CMD_TURN_OFF_WAIT_TIME, 16'he003, 1'b1);
    wreg(CMD_RAMP_DOWN_DURATION, 16'hf801, 1'b1);
    power_cycle("programmed", 5, 8, 3, 8);
    wreg(CMD_RAMP_DOWN_DURATION, 16'he007, 1'b1);
    power_cycle("fast off", 5, 8, 3, 7);
    // mid-run reset must restore every setting and the slow fall
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) rreg(codes[i], rsts[i]);
    power_cycle("defaults after reset", 0, 80, 0, 80);
    summarize();
  end
endmodule
